/* shared/ncci_pkg.sv */
`default_nettype none
package ncci_pkg;
  // Array geometry of the card.
  localparam int PAGES = 16384;
  localparam int BLOCK_PAGES = 16;
  localparam int BLOCKS = 1024;
  localparam logic [9:0] PAGE_COLS = 10'h210;
  localparam logic [9:0] HALF_COL = 10'h100;
  localparam logic [9:0] SPARE_COL = 10'h200;
  localparam logic [9:0] BAD_COL = 10'h205;
  localparam logic [3:0] BAD_ZEROS = 4'h2;
  localparam int ADDR_CYC_PAGE = 3;
  localparam int ADDR_CYC_BLOCK = 2;
  // Command bytes.
  localparam logic [7:0] CMD_READ_A = 8'h00;
  localparam logic [7:0] CMD_READ_B = 8'h01;
  localparam logic [7:0] CMD_READ_SPARE = 8'h50;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] CMD_PROG = 8'h80;
  localparam logic [7:0] CMD_PROG_GO = 8'h10;
  localparam logic [7:0] CMD_ERASE = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO = 8'hD0;
  localparam logic [7:0] ID_ADDR = 8'h00;
  // Timing, in the printed unit and as clock counts at 50 ns.
  localparam int CLK_NS = 50;
  localparam int T_WB_NS = 100;
  localparam int T_R_US = 10;
  localparam int T_PROG_US = 500;
  localparam int T_BERS_US = 4000;
  localparam logic [16:0] WB_CYC = 17'((T_WB_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [16:0] R_CYC = 17'((T_R_US * 1000) / CLK_NS);
  localparam logic [16:0] PROG_CYC = 17'((T_PROG_US * 1000) / CLK_NS);
  localparam logic [16:0] BERS_CYC = 17'((T_BERS_US * 1000) / CLK_NS);
  // Write data buffer shape.
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 8;

  typedef enum logic [2:0] {
    OP_READ_A, OP_READ_B, OP_READ_SPARE, OP_ID, OP_STATUS, OP_PROG, OP_ERASE, OP_RESET
  } ncci_op_e;

  // One user request: page row, start column and byte count.
  typedef struct packed {
    ncci_op_e op;
    logic [13:0] row;
    logic [7:0] col;
    logic [9:0] len;
  } ncci_req_s;

  // Card pins driven by the controller.
  typedef struct packed {
    logic cle;
    logic ale;
    logic cs_n;
    logic in_strobe_n;
    logic out_strobe_n;
    logic lock_n;
    logic data_oe;
    logic [7:0] data;
  } ncci_pins_s;
endpackage : ncci_pkg
`default_nettype wire

/* design/ncci_fifo.sv */
`default_nettype none
module ncci_fifo #(
  parameter int W = ncci_pkg::FIFO_W,
  parameter int D = ncci_pkg::FIFO_D
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic rdy_r, rdy_nxt, ov_r, ov_nxt;
  logic [W-1:0] od_r, od_nxt;
  logic push, pop;

  // Push when a slot is free; pop into the output register when it empties.
  assign push = in_valid_i && rdy_r;
  assign pop = (cnt_r != '0) && (!ov_r || out_ready_i);

  // Next pointers, fill level and output register.
  always_comb begin
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = pop ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
    rdy_nxt = (cnt_nxt != (AW+1)'(D));
    ov_nxt = pop ? 1'b1 : (out_ready_i ? 1'b0 : ov_r);
    od_nxt = pop ? mem_r[rp_r] : od_r;
  end

  // State registers.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      rdy_r <= 1'b0;
      ov_r <= 1'b0;
      od_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      rdy_r <= rdy_nxt;
      ov_r <= ov_nxt;
      od_r <= od_nxt;
    end
  end

  // Storage array, written without reset.
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem_r[wp_r] <= in_data_i;
    end
  end

  assign in_ready_o = rdy_r;
  assign out_valid_o = ov_r;
  assign out_data_o = od_r;
endmodule : ncci_fifo
`default_nettype wire

/* design/ncci_host.sv */
`default_nettype none
module ncci_host #(
  parameter logic [16:0] PROG_WAIT_CYC = ncci_pkg::PROG_CYC,
  parameter logic [16:0] ERASE_WAIT_CYC = ncci_pkg::BERS_CYC
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic req_valid_i,
  input wire ncci_pkg::ncci_req_s req_i,
  output logic req_ready_o,
  input wire logic wr_valid_i,
  input wire logic [7:0] wr_data_i,
  output logic wr_ready_o,
  output logic rd_valid_o,
  output logic [7:0] rd_data_o,
  output logic done_o,
  output logic bad_o,
  output logic timeout_o,
  input wire logic busy_n_i,
  input wire logic [7:0] data_i,
  output ncci_pkg::ncci_pins_s pins_o
);
  typedef enum logic [2:0] {S_IDLE, S_GATE, S_CMD, S_ADDR, S_WDATA, S_BUSY, S_RDATA, S_DONE}
    ncci_state_e;

  ncci_state_e st_r, st_nxt;
  ncci_pkg::ncci_req_s req_r, req_nxt;
  ncci_pkg::ncci_pins_s pins_r, pins_nxt;
  logic [1:0] ph_r, ph_nxt;
  logic [9:0] idx_r, idx_nxt, col_r, col_nxt;
  logic [16:0] wait_r, wait_nxt, limit;
  logic conf_r, conf_nxt, bad_r, bad_nxt, tmo_r, tmo_nxt;
  logic rdv_r, rdv_nxt, done_r, done_nxt, rdy_r, rdy_nxt;
  logic [7:0] rdd_r, rdd_nxt;
  logic f_valid, f_pop, wr_st;
  logic [7:0] f_data;

  // Count of zero bits in a byte.
  function automatic logic [3:0] zero_cnt(input logic [7:0] b);
    zero_cnt = 4'h0;
    for (int i = 0; i < 8; i++) begin
      zero_cnt = zero_cnt + {3'b000, ~b[i]};
    end
  endfunction : zero_cnt

  // Setup or confirm byte for the current operation.
  function automatic logic [7:0] cmd_byte(input ncci_pkg::ncci_op_e op, input logic conf);
    case (op)
      ncci_pkg::OP_READ_B: cmd_byte = ncci_pkg::CMD_READ_B;
      ncci_pkg::OP_READ_SPARE: cmd_byte = ncci_pkg::CMD_READ_SPARE;
      ncci_pkg::OP_ID: cmd_byte = ncci_pkg::CMD_READ_ID;
      ncci_pkg::OP_STATUS: cmd_byte = ncci_pkg::CMD_STATUS;
      ncci_pkg::OP_RESET: cmd_byte = ncci_pkg::CMD_RESET;
      ncci_pkg::OP_PROG: cmd_byte = conf ? ncci_pkg::CMD_PROG_GO : ncci_pkg::CMD_PROG;
      ncci_pkg::OP_ERASE: cmd_byte = conf ? ncci_pkg::CMD_ERASE_GO : ncci_pkg::CMD_ERASE;
      default: cmd_byte = ncci_pkg::CMD_READ_A;
    endcase
  endfunction : cmd_byte

  // Address byte number i; erase skips the column byte.
  function automatic logic [7:0] addr_byte(input ncci_pkg::ncci_req_s r, input logic [9:0] i);
    logic [1:0] k;
    k = (r.op == ncci_pkg::OP_ERASE) ? i[1:0] + 2'd1 : i[1:0];
    case (k)
      2'd0: addr_byte = (r.op == ncci_pkg::OP_ID) ? ncci_pkg::ID_ADDR : r.col;
      2'd1: addr_byte = r.row[7:0];
      default: addr_byte = {2'b00, r.row[13:8]};
    endcase
  endfunction : addr_byte

  // Number of address cycles for an operation.
  function automatic logic [9:0] addr_cnt(input ncci_pkg::ncci_op_e op);
    case (op)
      ncci_pkg::OP_ID: addr_cnt = 10'd1;
      ncci_pkg::OP_ERASE: addr_cnt = 10'(ncci_pkg::ADDR_CYC_BLOCK);
      default: addr_cnt = 10'(ncci_pkg::ADDR_CYC_PAGE);
    endcase
  endfunction : addr_cnt

  ncci_fifo #(.W(ncci_pkg::FIFO_W), .D(ncci_pkg::FIFO_D)) u_wbuf (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .in_valid_i(wr_valid_i),
    .in_ready_o(wr_ready_o),
    .in_data_i(wr_data_i),
    .out_valid_o(f_valid),
    .out_ready_i(f_pop),
    .out_data_o(f_data)
  );

  assign wr_st = (st_r == S_CMD) || (st_r == S_ADDR) || (st_r == S_WDATA);
  assign f_pop = (st_r == S_WDATA) && (ph_r == 2'd0);

  // Busy timeout limit by operation.
  always_comb begin
    case (req_r.op)
      ncci_pkg::OP_PROG: limit = PROG_WAIT_CYC;
      ncci_pkg::OP_ERASE, ncci_pkg::OP_RESET: limit = ERASE_WAIT_CYC;
      default: limit = ncci_pkg::R_CYC;
    endcase
  end

  // Sequencer: each byte is setup, strobe low, hold, one clock each except a data byte's setup, which waits for the buffer.
  always_comb begin
    st_nxt = st_r;
    req_nxt = req_r;
    ph_nxt = ph_r;
    idx_nxt = idx_r;
    col_nxt = col_r;
    wait_nxt = wait_r;
    conf_nxt = conf_r;
    bad_nxt = bad_r;
    tmo_nxt = tmo_r;
    rdv_nxt = 1'b0;
    rdd_nxt = rdd_r;
    done_nxt = 1'b0;
    case (st_r)
      S_IDLE: begin
        // A request is taken only at an edge where ready is shown, so one offer makes one request.
        if (req_valid_i && rdy_r) begin
          req_nxt = req_i;
          st_nxt = S_GATE;
          bad_nxt = 1'b0;
          tmo_nxt = 1'b0;
          case (req_i.op)
            ncci_pkg::OP_READ_B: col_nxt = ncci_pkg::HALF_COL | {2'b00, req_i.col};
            ncci_pkg::OP_READ_SPARE: col_nxt = ncci_pkg::SPARE_COL | {6'h00, req_i.col[3:0]};
            default: col_nxt = {2'b00, req_i.col};
          endcase
        end
      end
      S_GATE: begin
        if (busy_n_i || req_r.op == ncci_pkg::OP_STATUS || req_r.op == ncci_pkg::OP_RESET) begin
          st_nxt = S_CMD;
          conf_nxt = 1'b0;
          ph_nxt = 2'd0;
          idx_nxt = '0;
        end
      end
      S_CMD, S_ADDR, S_WDATA: begin
        if (ph_r == 2'd0) begin
          if (st_r != S_WDATA || f_valid) begin
            ph_nxt = 2'd1;
          end
        end else if (ph_r == 2'd1) begin
          ph_nxt = 2'd2;
        end else begin
          ph_nxt = 2'd0;
          idx_nxt = idx_r + 10'd1;
          if (st_r == S_CMD) begin
            idx_nxt = '0;
            wait_nxt = '0;
            if (conf_r || req_r.op == ncci_pkg::OP_RESET) begin
              st_nxt = S_BUSY;
            end else if (req_r.op == ncci_pkg::OP_STATUS) begin
              st_nxt = S_RDATA;
            end else begin
              st_nxt = S_ADDR;
            end
          end else if (st_r == S_ADDR && idx_r == addr_cnt(req_r.op) - 10'd1) begin
            // address then data; address then confirm.
            idx_nxt = '0;
            wait_nxt = '0;
            case (req_r.op)
              ncci_pkg::OP_ID: st_nxt = S_RDATA;
              ncci_pkg::OP_PROG: st_nxt = S_WDATA;
              ncci_pkg::OP_ERASE: begin
                st_nxt = S_CMD;
                conf_nxt = 1'b1;
              end
              default: st_nxt = S_BUSY;
            endcase
          end else if (st_r == S_WDATA && idx_r == req_r.len - 10'd1) begin
            // confirm after the last data byte.
            idx_nxt = '0;
            st_nxt = S_CMD;
            conf_nxt = 1'b1;
          end
        end
      end
      S_BUSY: begin
        wait_nxt = wait_r + 17'd1;
        if (wait_r >= ncci_pkg::WB_CYC && busy_n_i) begin
          st_nxt = (req_r.op == ncci_pkg::OP_PROG || req_r.op == ncci_pkg::OP_ERASE ||
                    req_r.op == ncci_pkg::OP_RESET) ? S_DONE : S_RDATA;
          ph_nxt = 2'd0;
        end else if (wait_r >= limit) begin
          tmo_nxt = 1'b1;
          st_nxt = S_DONE;
        end
      end
      S_RDATA: begin
        if (ph_r == 2'd0) begin
          ph_nxt = 2'd1;
        end else if (ph_r == 2'd1) begin
          ph_nxt = 2'd2;
          rdv_nxt = 1'b1;
          rdd_nxt = data_i;
          col_nxt = col_r + 10'd1;
          if (col_r == ncci_pkg::BAD_COL && zero_cnt(data_i) >= ncci_pkg::BAD_ZEROS &&
              req_r.op != ncci_pkg::OP_ID && req_r.op != ncci_pkg::OP_STATUS) begin
            bad_nxt = 1'b1;
          end
        end else begin
          ph_nxt = 2'd0;
          idx_nxt = idx_r + 10'd1;
          if (idx_r + 10'd1 >= req_r.len) begin
            st_nxt = S_DONE;
          end
        end
      end
      S_DONE: begin
        done_nxt = 1'b1;
        st_nxt = S_IDLE;
      end
      default: st_nxt = S_IDLE;
    endcase
  end

  // Pin values for the coming cycle.
  always_comb begin
    pins_nxt = pins_r;
    rdy_nxt = (st_nxt == S_IDLE);
    // select stays low across a whole read, released only at the end.
    pins_nxt.cs_n = (st_nxt == S_IDLE) || (st_nxt == S_GATE) || (st_nxt == S_DONE);
    // command latch held over setup, strobe and hold.
    pins_nxt.cle = (st_nxt == S_CMD);
    pins_nxt.ale = (st_nxt == S_ADDR);
    // data cycles strobe with both latches low.
    pins_nxt.in_strobe_n = !(((st_nxt == S_CMD) || (st_nxt == S_ADDR) || (st_nxt == S_WDATA)) &&
                             (ph_nxt == 2'd1));
    pins_nxt.out_strobe_n = !((st_nxt == S_RDATA) && (ph_nxt == 2'd1));
    pins_nxt.data_oe = (st_nxt == S_CMD) || (st_nxt == S_ADDR) || (st_nxt == S_WDATA);
    pins_nxt.lock_n = (st_nxt != S_IDLE) &&
                      (req_nxt.op == ncci_pkg::OP_PROG || req_nxt.op == ncci_pkg::OP_ERASE);
    if (wr_st && ph_r == 2'd0 && ph_nxt == 2'd1) begin
      case (st_r)
        // a fresh pointer command is sent for every read.
        S_CMD: pins_nxt.data = cmd_byte(req_r.op, conf_r);
        S_ADDR: pins_nxt.data = addr_byte(req_r, idx_r);
        default: pins_nxt.data = f_data;
      endcase
    end
  end

  // State registers.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r <= S_IDLE;
      req_r <= '0;
      ph_r <= 2'd0;
      idx_r <= '0;
      col_r <= '0;
      wait_r <= '0;
      conf_r <= 1'b0;
      bad_r <= 1'b0;
      tmo_r <= 1'b0;
      rdv_r <= 1'b0;
      rdd_r <= '0;
      done_r <= 1'b0;
      rdy_r <= 1'b0;
      pins_r <= '{cle: 1'b0, ale: 1'b0, cs_n: 1'b1, in_strobe_n: 1'b1, out_strobe_n: 1'b1,
                  lock_n: 1'b0, data_oe: 1'b0, data: 8'h00};
    end else begin
      st_r <= st_nxt;
      req_r <= req_nxt;
      ph_r <= ph_nxt;
      idx_r <= idx_nxt;
      col_r <= col_nxt;
      wait_r <= wait_nxt;
      conf_r <= conf_nxt;
      bad_r <= bad_nxt;
      tmo_r <= tmo_nxt;
      rdv_r <= rdv_nxt;
      rdd_r <= rdd_nxt;
      done_r <= done_nxt;
      rdy_r <= rdy_nxt;
      pins_r <= pins_nxt;
    end
  end

  assign pins_o = pins_r;
  assign req_ready_o = rdy_r;
  assign rd_valid_o = rdv_r;
  assign rd_data_o = rdd_r;
  assign done_o = done_r;
  assign bad_o = bad_r;
  assign timeout_o = tmo_r;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  // Data byte: strobe low with the bus driven and select low, then high with the byte held.
  sequence s_in_pulse;
    !pins_r.in_strobe_n && pins_r.data_oe && !pins_r.cs_n ##1
      pins_r.in_strobe_n && $stable(pins_r.data);
  endsequence
  a_cmd_latch: assert property ($fell(pins_r.in_strobe_n) && pins_r.cle |->
    !pins_r.ale && !pins_r.cs_n && pins_r.data_oe ##1 pins_r.cle && $stable(pins_r.data))
    else $error("command strobe without proper latch");
  a_addr_latch: assert property ($fell(pins_r.in_strobe_n) && pins_r.ale |->
    !pins_r.cle && pins_r.data_oe ##1 pins_r.ale && $stable(pins_r.data))
    else $error("address strobe without proper latch");
  a_strobe_shape: assert property ($fell(pins_r.in_strobe_n) && !pins_r.cle &&
    !pins_r.ale |-> s_in_pulse)
    else $error("input strobe pulse malformed");
  a_strobe_width: assert property ($fell(pins_r.in_strobe_n) |=> $rose(pins_r.in_strobe_n))
    else $error("input strobe not one cycle low");
  a_erase_rows: assert property ($fell(pins_r.in_strobe_n) && pins_r.ale &&
    req_r.op == ncci_pkg::OP_ERASE |-> idx_r < 10'd2)
    else $error("erase sent a third address cycle");
  a_prog_go: assert property ($fell(pins_r.in_strobe_n) && pins_r.cle &&
    pins_r.data == ncci_pkg::CMD_PROG_GO |-> req_r.op == ncci_pkg::OP_PROG && pins_r.lock_n)
    else $error("program confirm out of sequence");
  a_busy_gate: assert property ($rose(pins_r.cle) && !conf_r && !busy_n_i |->
    req_r.op == ncci_pkg::OP_STATUS || req_r.op == ncci_pkg::OP_RESET)
    else $error("command issued while card busy");
  a_read_sample: assert property ($fell(pins_r.out_strobe_n) |-> !pins_r.data_oe &&
    !pins_r.cs_n ##1 rd_valid_o && pins_r.out_strobe_n)
    else $error("read strobe did not yield one byte");
  a_erase_order: assert property ($fell(pins_r.in_strobe_n) && pins_r.cle &&
    pins_r.data == ncci_pkg::CMD_ERASE_GO |-> $past(st_r, 4) == S_ADDR)
    else $error("erase execute not after row cycles");
endmodule : ncci_host
`default_nettype wire

/* testbench/ncci_card_model.sv */
`default_nettype none
module ncci_card_model #(
  parameter logic [7:0] MAKER_CODE = 8'hA5, // Arbitrary value.
  parameter logic [7:0] DEVICE_CODE = 8'h3C // Arbitrary value.
) (
  input wire ncci_pkg::ncci_pins_s pins_i,
  input wire logic [7:0] bus_i,
  input wire logic hang_i,
  output logic busy_n_o,
  output logic [7:0] data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Flat array of 528-column pages, erased bytes read as all ones.
  logic [7:0] mem [int];
  logic [7:0] pbuf [528];
  logic [7:0] cmd = 8'h00;
  logic [7:0] dout = 8'h00;
  logic [13:0] row = 14'h0000;
  int col = 0;
  int base = 0;
  int nadr = 0;
  int k = 0;
  initial busy_n_o = 1'b1;

  function automatic logic [7:0] rd(input int a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction : rd

  // Busy is pulled low, then released after the operation time.
  task automatic go_busy(input int ns);
    busy_n_o = 1'b0;
    busy_n_o <= #(ns) 1'b1;
  endtask : go_busy

  // Command, address and data latch on the write strobe rise.
  always @(posedge pins_i.in_strobe_n) begin
    if (!pins_i.cs_n && pins_i.cle && (busy_n_o || bus_i inside {8'hFF, 8'h70})) begin
      cmd = bus_i;
      nadr = 0;
      case (bus_i)
        8'h00, 8'h80, 8'h90: begin
          base = 0;
          foreach (pbuf[i]) pbuf[i] = 8'hFF;
        end
        8'h01: base = 256;
        8'h50: base = 512;
        8'hFF: go_busy(500);
        8'h10: begin
          if (pins_i.lock_n) foreach (pbuf[i]) mem[row * 528 + i] = rd(row * 528 + i) & pbuf[i];
          go_busy(1500);
        end
        8'hD0: begin
          if (pins_i.lock_n) for (int p = 0; p < 16; p++) for (int c = 0; c < 528; c++)
            mem.delete({row[13:4], 4'(p)} * 528 + c);
          go_busy(2000);
        end
        default: ;
      endcase
    end else if (!pins_i.cs_n && pins_i.ale && busy_n_o) begin
      // Column, low row, high row; erase skips the column cycle.
      k = (cmd == 8'h60) ? nadr + 1 : nadr;
      if (k == 0) col = base + ((base == 512) ? int'(bus_i[3:0]) : int'(bus_i));
      if (k == 1) row[7:0] = bus_i;
      if (k == 2) row[13:8] = bus_i[5:0];
      // Page transfer, then the half pointer returns to the first half.
      if (k == 2 && cmd inside {8'h00, 8'h01, 8'h50}) begin
        go_busy(hang_i ? 15000 : 1000);
        base = 0;
      end
      nadr++;
    end else if (!pins_i.cs_n && !pins_i.cle && !pins_i.ale && busy_n_o && cmd == 8'h80) begin
      // Data byte into the page register.
      if (col < 528) pbuf[col] = bus_i;
      col++;
    end
  end

  // Deselect ends a read but not a program or erase in progress.
  always @(posedge pins_i.cs_n) begin
    if (busy_n_o || !(cmd inside {8'h10, 8'hD0})) nadr = 0;
  end

  // Read strobe fall presents a byte and advances the column.
  always @(negedge pins_i.out_strobe_n) begin
    if (!pins_i.cs_n) begin
      if (cmd == 8'h70) dout = {pins_i.lock_n, busy_n_o, 6'h00};
      else if (cmd == 8'h90) dout = (col == 0) ? MAKER_CODE : DEVICE_CODE;
      else dout = rd(row * 528 + col);
      col++;
    end
  end

  // Released bus shows the inverse of the last byte.
  assign data_o = (!pins_i.cs_n && !pins_i.out_strobe_n) ? dout : ~dout;
endmodule : ncci_card_model
`default_nettype wire

/* testbench/ncci_host_tb.sv */
`default_nettype none
module ncci_host_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] ID_A = 8'hA5; // Arbitrary value.
  localparam logic [7:0] ID_B = 8'h3C; // Arbitrary value.
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic req_valid_i = 1'b0;
  logic wr_valid_i = 1'b0;
  logic wr_go = 1'b0;
  logic hang = 1'b0;
  logic [7:0] wr_data_i = 8'h00;
  ncci_pkg::ncci_req_s req_i = '0;
  logic req_ready_o, wr_ready_o, rd_valid_o, done_o, bad_o, timeout_o, busy_n;
  logic bad_seen, to_seen, saw_full;
  logic [7:0] rd_data_o, card_data, bus;
  ncci_pkg::ncci_pins_s pins;
  int n_errors = 0;
  int total_checks = 0;
  int done_cnt = 0;
  logic [7:0] rdq [$];
  logic [7:0] wq [$];
  logic [7:0] ref_mem [int];

  // Shared data wire: host drives it while its enable is high.
  assign bus = pins.data_oe ? pins.data : card_data;

  ncci_host #(.PROG_WAIT_CYC(17'h0032), .ERASE_WAIT_CYC(17'h003C)) ncci_host_inst (
    .clock_i(clock_i), .resetn_i(resetn_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .req_ready_o(req_ready_o), .wr_valid_i(wr_valid_i), .wr_data_i(wr_data_i),
    .wr_ready_o(wr_ready_o), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .done_o(done_o),
    .bad_o(bad_o), .timeout_o(timeout_o), .busy_n_i(busy_n), .data_i(bus), .pins_o(pins));

  ncci_card_model #(.MAKER_CODE(ID_A), .DEVICE_CODE(ID_B)) ncci_card_model_inst (
    .pins_i(pins), .bus_i(bus), .hang_i(hang), .busy_n_o(busy_n), .data_o(card_data));

  initial forever #25 clock_i = ~clock_i;

  // Collects read bytes, end-of-request flags and buffer back-pressure.
  always @(posedge clock_i) begin
    if (rd_valid_o) rdq.push_back(rd_data_o);
    if (done_o) begin
      done_cnt++;
      bad_seen = bad_o;
      to_seen = timeout_o;
    end
    if (resetn_i && !wr_ready_o) saw_full = 1'b1;
  end

  // Feeds program bytes with random gaps; a raised valid is held until taken.
  initial forever begin
    @(posedge clock_i);
    #2;
    if (wr_go) void'(wq.pop_front());
    wr_valid_i = (wq.size() > 0) && (wr_valid_i || ($urandom_range(3) != 0));
    wr_data_i = (wq.size() > 0) ? wq[0] : 8'h00;
    wr_go = wr_valid_i && wr_ready_o;
  end

  function automatic int key(input logic [13:0] r, input int c);
    return r * 528 + c;
  endfunction : key

  function automatic logic [7:0] exp_b(input logic [13:0] r, input int c);
    return ref_mem.exists(key(r, c)) ? ref_mem[key(r, c)] : 8'hFF;
  endfunction : exp_b

  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic conclude();
    if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude

  task automatic do_req(input ncci_pkg::ncci_op_e op, input logic [13:0] row,
                        input logic [7:0] col, input logic [9:0] len);
    int d0;
    int k;
    rdq.delete();
    d0 = done_cnt;
    k = 0;
    req_i = '{op: op, row: row, col: col, len: len};
    req_valid_i = 1'b1;
    while (!req_ready_o) begin
      @(posedge clock_i);
      #2;
    end
    @(posedge clock_i);
    #2;
    req_valid_i = 1'b0;
    while (done_cnt == d0 && k < 20000) begin
      @(posedge clock_i);
      #2;
      k++;
    end
    if (done_cnt == d0) chk("request done", 8'h01, 8'h00);
  endtask : do_req

  task automatic rd_chk(input ncci_pkg::ncci_op_e op, input logic [13:0] row, input int col,
                        input int base, input int len);
    do_req(op, row, 8'(col), 10'(len));
    chk("read count", 8'(len), 8'(rdq.size()));
    for (int i = 0; i < len; i++) chk("read byte", exp_b(row, base + col + i), rdq[i]);
  endtask : rd_chk

  initial begin : main
    logic [13:0] r;
    logic [7:0] v;
    int c;
    int n;
    void'($urandom(20));
    repeat (12) @(posedge clock_i);
    #2;
    resetn_i = 1'b1;
    do_req(ncci_pkg::OP_STATUS, 14'h0000, 8'h00, 10'h001);
    chk("status idle", 8'h40, rdq[0]);
    do_req(ncci_pkg::OP_ID, 14'h0000, 8'h00, 10'h002);
    chk("id first", ID_A, rdq[0]);
    chk("id second", ID_B, rdq[1]);
    // Random programs, each read back; the first overfills the buffer.
    for (int t = 0; t < 4; t++) begin
      r = 14'($urandom);
      c = $urandom_range(180);
      n = (t == 0) ? 14 + $urandom_range(20) : 1 + $urandom_range(40);
      for (int i = 0; i < n; i++) begin
        v = 8'($urandom);
        wq.push_back(v);
        ref_mem[key(r, c + i)] = exp_b(r, c + i) & v;
      end
      saw_full = 1'b0;
      repeat (20) @(posedge clock_i);
      #2;
      do_req(ncci_pkg::OP_PROG, r, 8'(c), 10'(n));
      chk("buffer drained", 8'h00, 8'(wq.size()));
      if (t == 0) chk("buffer full", 8'h01, {7'h00, saw_full});
      rd_chk(ncci_pkg::OP_READ_A, r, c, 0, n);
    end
    // Erase the block of the last page through a random page of it.
    do_req(ncci_pkg::OP_ERASE, {r[13:4], 4'($urandom)}, 8'h00, 10'h001);
    for (int p = 0; p < 16; p++) begin
      for (int i = 0; i < 528; i++) ref_mem.delete(key({r[13:4], 4'(p)}, i));
    end
    rd_chk(ncci_pkg::OP_READ_A, r, c, 0, n);
    // Second register half, then the first half again.
    r = 14'($urandom);
    c = $urandom_range(200);
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      ncci_card_model_inst.mem[key(r, 256 + c + i)] = v;
      ref_mem[key(r, 256 + c + i)] = v;
    end
    rd_chk(ncci_pkg::OP_READ_B, r, c, 256, 4);
    rd_chk(ncci_pkg::OP_READ_A, r, c, 0, 4);
    // Marker byte with exactly two zero bits, then with one.
    for (int j = 0; j < 2; j++) begin
      r = 14'($urandom);
      v = (j == 0) ? 8'hFC : 8'hFE;
      ncci_card_model_inst.mem[key(r, 517)] = v;
      ref_mem[key(r, 517)] = v;
      rd_chk(ncci_pkg::OP_READ_SPARE, r, 0, 512, 8);
      chk("bad flag", {7'h00, j == 0}, {7'h00, bad_seen});
    end
    // A page transfer longer than the read timeout, then status and reset while busy.
    hang = 1'b1;
    do_req(ncci_pkg::OP_READ_A, r, 8'h00, 10'h001);
    hang = 1'b0;
    chk("timeout flag", 8'h01, {7'h00, to_seen});
    do_req(ncci_pkg::OP_STATUS, 14'h0000, 8'h00, 10'h001);
    chk("status busy", 8'h00, rdq[0]);
    do_req(ncci_pkg::OP_RESET, 14'h0000, 8'h00, 10'h001);
    chk("reset timeout", 8'h00, {7'h00, to_seen});
    do_req(ncci_pkg::OP_STATUS, 14'h0000, 8'h00, 10'h001);
    chk("status ready", 8'h40, rdq[0]);
    conclude();
  end : main

  // Cuts a hung run short; the whole test needs a few thousand cycles, this allows 40000.
  initial begin
    #2000000;
    n_errors++;
    conclude();
  end
endmodule : ncci_host_tb
`default_nettype wire
